// >>> pomux_top.sv
// Output-side pin mux of the second switch port, with its stream FIFO.
// Assumes the reference clock pin is slow against clk and is sampled here.
`timescale 1ns/1ps
module pomux_top #(
  parameter int DEPTH = pomux_pkg::FIFO_DEPTH
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             clk_en,
  input  wire logic [2:0]                       port_interface_mode_strap,
  input  wire logic                             isolate,
  input  wire logic                             rmii_clk_dir_out,
  input  wire logic                             port_out_ref_clock_in,
  output logic                                  port_out_ref_clock_out,
  output logic                                  port_out_ref_clock_oe,
  output logic                                  port_out_ref_clock_strong,
  input  wire logic                             sw_valid,
  output logic                                  sw_ready,
  input  wire logic [pomux_pkg::MII_WIDTH-1:0]  sw_data,
  input  wire logic                             sw_frame,
  output logic      [pomux_pkg::MII_WIDTH-1:0]  port_out_data,
  output logic      [pomux_pkg::MII_WIDTH-1:0]  port_out_data_oe,
  output logic                                  port_out_data_valid,
  output logic                                  port_out_data_valid_oe
);
  import pomux_pkg::*;

  // Strap caught once after reset release, never in the reset branch
  logic [2:0]       mode_q, mode_d;
  logic             caught_q, caught_d;
  // Strap is a pin: two flops before the capture reads it
  logic [2:0]       strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;
  logic [1:0]       settle_q, settle_d;
  logic [SYNC_STAGES-1:0] sync_q, sync_d;
  logic             ref_prev_q, ref_prev_d;
  logic             div_q, div_d;
  logic             edge_hit;
  pomux_path_e      path;
  logic             clk_is_out;
  logic             fifo_valid, fifo_pop;
  logic [MII_WIDTH:0] fifo_data;
  logic [MII_WIDTH-1:0] dat_q, dat_d, doe_q, doe_d;
  logic             dv_q, dv_d, dvoe_q, dvoe_d;
  logic             cko_q, cko_d, ckoe_q, ckoe_d, ckst_q, ckst_d;

  function automatic pomux_path_e path_of(input logic [2:0] m);
    case (m)
      MODE_MII_MAC, MODE_MII_PHY,
      MODE_MII_PHY_200L, MODE_MII_PHY_200H: path_of = POMUX_PATH_MII;
      MODE_RMII_OUT_L, MODE_RMII_OUT_H,
      MODE_RMII_IN:                         path_of = POMUX_PATH_RMII;
      default:                              path_of = POMUX_PATH_NONE;
    endcase
  endfunction

  pomux_fifo #(
    .WIDTH (MII_WIDTH + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (sw_valid),
    .in_ready  (sw_ready),
    .in_data   ({sw_frame, sw_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_comb begin
    path       = path_of(mode_q);
    strap_s1_d = port_interface_mode_strap;
    strap_s2_d = strap_s1_q;
    settle_d   = {settle_q[0], 1'b1};
    mode_d     = caught_q ? mode_q : strap_s2_q;
    // Capture only once both strap stages hold the pin value
    caught_d   = caught_q || settle_q[1];
    sync_d     = {sync_q[SYNC_STAGES-2:0], port_out_ref_clock_in};
    // Only the last synchroniser stage feeds the edge detector
    ref_prev_d = sync_q[SYNC_STAGES-1];
    div_d      = ~div_q;
    // Driven clock is a divided core clock; real 50 MHz needs a faster source
    clk_is_out = (mode_q == MODE_MII_PHY) || (mode_q == MODE_MII_PHY_200L) ||
                 (mode_q == MODE_MII_PHY_200H) || (mode_q == MODE_RMII_OUT_L) ||
                 (mode_q == MODE_RMII_OUT_H) ||
                 ((mode_q == MODE_RMII_IN) && rmii_clk_dir_out);
    edge_hit   = clk_is_out ? (div_q == 1'b0)
                            : (sync_q[SYNC_STAGES-1] && !ref_prev_q);
    fifo_pop   = caught_q && edge_hit && (path != POMUX_PATH_NONE);
    cko_d      = div_q;
    ckoe_d     = caught_q && clk_is_out && !isolate;
    ckst_d     = (mode_q == MODE_MII_PHY_200H) || (mode_q == MODE_RMII_OUT_H);
    dat_d      = dat_q;
    dv_d       = dv_q;
    if (fifo_pop) begin
      dv_d  = fifo_valid && fifo_data[MII_WIDTH];
      dat_d = fifo_valid ? fifo_data[MII_WIDTH-1:0] : '0;
      if (path == POMUX_PATH_RMII) begin
        dat_d = {2'h0, dat_d[RMII_WIDTH-1:0]};
      end
    end
    doe_d  = '0;
    dvoe_d = 1'b0;
    if (caught_q) begin
      case (path)
        POMUX_PATH_MII: begin
          doe_d  = (mode_q == MODE_MII_MAC || !isolate) ? 4'hF : 4'h0;
          dvoe_d = (mode_q == MODE_MII_MAC) || !isolate;
        end
        POMUX_PATH_RMII: begin
          doe_d  = isolate ? 4'h0 : 4'h3;
          dvoe_d = !isolate;
        end
        default: begin
          doe_d  = '0;
          dvoe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q     <= MODE_INT_PHY;
      caught_q   <= 1'b0;
      strap_s1_q <= MODE_INT_PHY;
      strap_s2_q <= MODE_INT_PHY;
      settle_q   <= 2'h0;
      sync_q     <= '0;
      ref_prev_q <= 1'b0;
      div_q      <= 1'b0;
      dat_q      <= '0;
      doe_q      <= '0;
      dv_q       <= 1'b0;
      dvoe_q     <= 1'b0;
      cko_q      <= 1'b0;
      ckoe_q     <= 1'b0;
      ckst_q     <= 1'b0;
    end else if (clk_en) begin
      mode_q     <= mode_d;
      caught_q   <= caught_d;
      strap_s1_q <= strap_s1_d;
      strap_s2_q <= strap_s2_d;
      settle_q   <= settle_d;
      sync_q     <= sync_d;
      ref_prev_q <= ref_prev_d;
      div_q      <= div_d;
      dat_q      <= dat_d;
      doe_q      <= doe_d;
      dv_q       <= dv_d;
      dvoe_q     <= dvoe_d;
      cko_q      <= cko_d;
      ckoe_q     <= ckoe_d;
      ckst_q     <= ckst_d;
    end
  end

  assign port_out_data             = dat_q;
  assign port_out_data_oe          = doe_q;
  assign port_out_data_valid       = dv_q;
  assign port_out_data_valid_oe    = dvoe_q;
  assign port_out_ref_clock_out    = cko_q;
  assign port_out_ref_clock_oe     = ckoe_q;
  assign port_out_ref_clock_strong = ckst_q;
endmodule

// Small flip-flop FIFO with valid/ready on both sides
module pomux_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  always_comb begin
    // Ready is taken from the next count so the top can drive it from a flop
    push      = in_valid && ready_q;
    pop       = (cnt_q != '0) && out_ready;
    in_ready  = ready_q;
    out_valid = cnt_q != '0;
    out_data  = mem_q[rd_q];
    mem_d     = mem_q;
    wr_d      = wr_q;
    rd_d      = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ready_d = cnt_d != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b1;
    end else if (clk_en) begin
      mem_q   <= mem_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
    end
  end
endmodule

// >>> pomux_pkg.sv
// Constants for the port output-side pin mux.
// Assumes a 20 MHz core clock that samples the port reference clock.
package pomux_pkg;
  localparam logic [2:0] MODE_MII_MAC      = 3'h0;
  localparam logic [2:0] MODE_MII_PHY      = 3'h1;
  localparam logic [2:0] MODE_MII_PHY_200L = 3'h2;
  localparam logic [2:0] MODE_MII_PHY_200H = 3'h3;
  localparam logic [2:0] MODE_RMII_OUT_L   = 3'h4;
  localparam logic [2:0] MODE_RMII_OUT_H   = 3'h5;
  localparam logic [2:0] MODE_RMII_IN      = 3'h6;
  localparam logic [2:0] MODE_INT_PHY      = 3'h7;
  localparam int         MII_WIDTH         = 4;
  localparam int         RMII_WIDTH        = 2;
  localparam int         FIFO_DEPTH        = 4;
  localparam int         CLK_RATE_HZ       = 20000000;
  localparam int         RMII_REF_MHZ      = 50;
  localparam int         SYNC_STAGES       = 2;
  typedef enum logic [1:0] {
    POMUX_PATH_MII,
    POMUX_PATH_RMII,
    POMUX_PATH_NONE
  } pomux_path_e;
endpackage

// >>> pomux_fifo.sv
// Stream FIFO of the output pin mux: its module sits in pomux_top.sv.
// Assumes nothing; this file declares no module of its own.

// >>> pomux_top_props.sv
// Checker bound to the output pin mux: driver enables, strength, pacing.
// Assumes the strap changes only in reset and clk_en stays high.
`timescale 1ns/1ps
module pomux_top_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [2:0] port_interface_mode_strap,
  input wire logic       isolate,
  input wire logic       port_out_ref_clock_out,
  input wire logic       port_out_ref_clock_oe,
  input wire logic       port_out_ref_clock_strong,
  input wire logic [3:0] port_out_data,
  input wire logic [3:0] port_out_data_oe,
  input wire logic       port_out_data_valid,
  input wire logic       port_out_data_valid_oe
);
  logic [1:0] up_q;
  logic [2:0] m;
  logic       ok;
  assign m = port_interface_mode_strap;
  // Strap only trusted once captured and outputs settled
  assign ok = clk_en && up_q == 2'h3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_on; port_out_data_oe == 4'hF && port_out_data_valid_oe; endsequence
  sequence s_off; port_out_data_oe == 4'h0 && !port_out_data_valid_oe; endsequence
  property p_mii_on; ok && m < 3'h4 && !(isolate && m != 3'h0) |=> s_on; endproperty
  a_mii_on: assert property (p_mii_on) else $error("MII pins not driven");
  property p_iso; ok && m inside {[3'h1:3'h6]} && isolate |=> s_off; endproperty
  a_iso: assert property (p_iso) else $error("isolated pins driven");
  property p_rmii; ok && m inside {[3'h4:3'h6]} && !isolate
    |=> port_out_data_oe == 4'h3; endproperty
  a_rmii: assert property (p_rmii) else $error("RMII data enables wrong");
  property p_int; ok && m == 3'h7 |=> s_off; endproperty
  a_int: assert property (p_int) else $error("internal mode pins driven");
  property p_strong; ok |=> port_out_ref_clock_strong == (m == 3'h3 || m == 3'h5); endproperty
  a_strong: assert property (p_strong) else $error("clock strength wrong");
  property p_mac_clk; ok && m == 3'h0 |=> !port_out_ref_clock_oe; endproperty
  a_mac_clk: assert property (p_mac_clk) else $error("MAC mode drives clock");
  property p_clk_out; ok && m inside {[3'h1:3'h5]} && !isolate
    |=> port_out_ref_clock_oe && port_out_ref_clock_out != $past(port_out_ref_clock_out);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock not driven");
  property p_pace; ok && !isolate && $changed({port_out_data_valid, port_out_data})
    |=> $stable({port_out_data_valid, port_out_data}); endproperty
  a_pace: assert property (p_pace) else $error("pins changed twice");
endmodule
bind pomux_top pomux_top_props pomux_top_props_i (.clk, .rst, .clk_en,
  .port_interface_mode_strap, .isolate, .port_out_ref_clock_out, .port_out_ref_clock_oe,
  .port_out_ref_clock_strong, .port_out_data, .port_out_data_oe, .port_out_data_valid,
  .port_out_data_valid_oe);

// >>> pomux_link_model.sv
// Far-side partner: free-running transmit clock and pin sampler.
// Assumes pins settle well within half a core period of their edge.
`timescale 1ns/1ps
module pomux_link_model (
  output logic            ref_clk,
  input  wire logic       pin_clk,
  input  wire logic       valid,
  input  wire logic [3:0] data
);
  logic [3:0] rx_q[$];
  // Phase offset keeps link edges off core edges
  initial begin
    ref_clk = 1'b0;
    #7;
    forever #200 ref_clk = !ref_clk;
  end
  // Sample inside the stable window, not on the edge itself
  always @(posedge pin_clk) begin
    #25;
    if (valid === 1'b1) rx_q.push_back(data);
  end
endmodule

// >>> pomux_top_tb_top.sv
// Self-checking bench for the output pin mux, mode by mode.
// Assumes the partner model samples the pins; checker is bound separately.
`timescale 1ns/1ps
module pomux_top_tb_top;
  logic       clk = 1'b0, rst = 1'b1, clk_en = 1'b1, isolate = 1'b0, rmii_clk_dir_out = 1'b0;
  logic       sw_valid = 1'b0, sw_frame = 1'b0, sw_ready, port_out_data_valid, link_clk;
  logic       port_out_data_valid_oe, port_out_ref_clock_out, port_out_ref_clock_oe;
  logic       port_out_ref_clock_strong, pin_clk;
  logic [2:0] port_interface_mode_strap = 3'h0;
  logic [3:0] sw_data = 4'h0, port_out_data, port_out_data_oe;
  int         n_errors = 0, checks_done = 0, cyc = 0;
  // Pin level: device clock while it drives, else the partner's
  assign pin_clk = port_out_ref_clock_oe ? port_out_ref_clock_out : link_clk;
  pomux_top pomux_top_i (.clk, .rst, .clk_en, .port_interface_mode_strap, .isolate,
    .rmii_clk_dir_out, .port_out_ref_clock_in(pin_clk), .port_out_ref_clock_out,
    .port_out_ref_clock_oe, .port_out_ref_clock_strong, .sw_valid, .sw_ready, .sw_data,
    .sw_frame, .port_out_data, .port_out_data_oe, .port_out_data_valid, .port_out_data_valid_oe);
  pomux_link_model pomux_link_model_i (.ref_clk(link_clk), .pin_clk,
    .valid(port_out_data_valid), .data(port_out_data));
  always #25 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] want);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic restart(input logic [2:0] mode, input logic dir);
    @(negedge clk);
    rst = 1'b1;
    isolate = 1'b0;
    port_interface_mode_strap = mode;
    rmii_clk_dir_out = dir;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    pomux_link_model_i.rx_q.delete();
  endtask
  // Leaves valid high so bursts run back to back
  task automatic send(input logic [3:0] d, input logic f);
    sw_valid = 1'b1;
    sw_data = d;
    sw_frame = f;
    while (sw_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic t_mode(input logic [2:0] mode, input logic dir);
    logic [3:0] mask;
    logic [3:0] want[$];
    mask = (mode inside {[3'h4:3'h6]}) ? 4'h3 : 4'hF;
    restart(mode, dir);
    for (int i = 0; i < 6; i++) begin
      send(4'(i * 5 + 3), i != 2);
      if (i != 2) want.push_back(4'(i * 5 + 3) & mask);
    end
    sw_valid = 1'b0;
    repeat (80) @(negedge clk);
    chk(4'(pomux_link_model_i.rx_q.size()), 4'(want.size()));
    foreach (want[k]) chk(pomux_link_model_i.rx_q[k], want[k]);
    chk({3'h0, port_out_ref_clock_oe}, {3'h0, (mode inside {[3'h1:3'h5]}) || dir});
    chk({3'h0, port_out_ref_clock_strong}, {3'h0, mode == 3'h3 || mode == 3'h5});
    isolate = 1'b1;
    repeat (3) @(negedge clk);
    chk(port_out_data_oe, mode == 3'h0 ? 4'hF : 4'h0);
    chk({3'h0, port_out_data_valid_oe}, {3'h0, mode == 3'h0});
    $display("mode %h done", mode);
  endtask
  task automatic t_int();
    restart(3'h7, 1'b0);
    for (int i = 0; i < 4; i++) send(4'(i), 1'b1);
    repeat (10) @(negedge clk);
    chk({3'h0, sw_ready}, 4'h0);
    chk(port_out_data_oe, 4'h0);
    chk({3'h0, port_out_data_valid_oe}, 4'h0);
    sw_valid = 1'b0;
    chk(4'(pomux_link_model_i.rx_q.size()), 4'h0);
    $display("internal mode done");
  endtask
  initial begin
    for (int m = 0; m < 7; m++) t_mode(3'(m), 1'b0);
    t_mode(3'h6, 1'b1);
    t_int();
    end_sim();
  end
endmodule
